/* rtl/rgt_pkg.sv */
// Constants for the receiver gain and response timer block.
// Assumes a 100 MHz system clock and a carrier near 13.56 MHz.
package rgt_pkg;

    // ************************************************************
    // Register indexes (byte address is four times the index)
    // ************************************************************
    localparam logic [5:0] IDX_GAIN = 6'h0d;
    localparam logic [5:0] IDX_MASK = 6'h0e;
    localparam logic [5:0] IDX_NRT_HI = 6'h0f;
    localparam logic [5:0] IDX_NRT_LO = 6'h10;
    localparam logic [5:0] IDX_CTRL = 6'h20;
    localparam logic [5:0] IDX_CMD = 6'h21;
    localparam logic [5:0] IDX_STATUS = 6'h22;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] RST_GAIN = 8'h00;
    localparam logic [7:0] RST_MASK = 8'h08;
    localparam logic [7:0] RST_NRT_HI = 8'h00;
    localparam logic [7:0] RST_NRT_LO = 8'h00;
    localparam logic [4:0] RST_CTRL = 5'h10;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int GAIN_AMP_LSB = 4;
    localparam int GAIN_PH_LSB = 0;
    localparam int CTRL_NRT_STEP = 0;
    localparam int CTRL_NFC_MODE = 1;
    localparam int CTRL_ACTIVE = 2;
    localparam int CTRL_BR_DET = 3;
    localparam int CTRL_SQ_AUTO = 4;
    localparam int CMD_SET_DEFAULT = 0;
    localparam int CMD_GAIN_RELOAD = 1;
    localparam int CMD_START_NRT = 2;
    localparam int ST_MASK = 0;
    localparam int ST_SQUELCH = 1;
    localparam int ST_NRT_RUN = 2;
    localparam int ST_NRT_FLAG = 3;

    // ************************************************************
    // Gain code limits
    // ************************************************************
    localparam logic [3:0] GAIN_WIN_MAX = 4'h4;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam logic [31:0] CLK_HZ = 32'h05f5e100;
    localparam logic [31:0] FC_HZ = 32'h00cee8c0;
    localparam logic [11:0] MASK_STEP = 12'h040;
    localparam logic [11:0] MASK_STEP_BR = 12'h200;
    localparam logic [7:0] MASK_MIN = 8'h04;
    localparam logic [11:0] NRT_STEP = 12'h040;
    localparam logic [12:0] NRT_STEP_LONG = 13'h1000;
    localparam logic [11:0] SQ_DELAY_FC = 12'h100;

    // ************************************************************
    // AXI responses
    // ************************************************************
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {NRT_IDLE, NRT_WAIT, NRT_RUN} rgt_nrt_t;

endpackage : rgt_pkg

/* rtl/rgt_top.sv */
// Receiver gain code, mask receive timer and no-response timer.
// Assumes an AXI4-Lite master and synchronous single-cycle event inputs.
`timescale 1ns/1ps
module rgt_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic tx_end,
    input wire logic ext_field_det,
    input wire logic rx_detect,
    input wire logic rx_raw,
    output logic rx_gated,
    output logic mask_active,
    output logic squelch_on,
    output logic no_reply_irq,
    output logic [2:0] amp_window_steps,
    output logic [2:0] amp_stage_steps,
    output logic [2:0] phase_window_steps,
    output logic [2:0] phase_stage_steps
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic aw_have;
        logic w_have;
        logic [5:0] aw_idx;
        logic aw_ok;
        logic [7:0] w_data;
        logic w_lane0;
        logic [7:0] gain;
        logic [7:0] mrt;
        logic [7:0] nrt_hi;
        logic [7:0] nrt_lo;
        logic [4:0] ctrl;
        logic [7:0] gain_live;
        logic [2:0] amp_win;
        logic [2:0] amp_stg;
        logic [2:0] ph_win;
        logic [2:0] ph_stg;
        logic [31:0] fc_acc;
        logic fc_tick;
        logic mask_on;
        logic [11:0] mask_pre;
        logic [7:0] mask_cnt;
        logic [11:0] sq_cnt;
        logic squelch;
        logic rx_out;
        rgt_pkg::rgt_nrt_t nrt_st;
        logic [12:0] nrt_pre;
        logic [15:0] nrt_cnt;
        logic nrt_irq;
        logic nrt_flag;
    } rgt_state_t;

    rgt_state_t q;
    rgt_state_t d;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb
    begin
        logic wr_fire;
        logic [5:0] ar_idx;
        logic [31:0] acc_sum;
        logic [7:0] cmd;
        logic [11:0] mstep;
        logic [12:0] nstep;
        logic [15:0] nrt_val;
        logic [3:0] code;
        wr_fire = 1'b0;
        ar_idx = 6'h00;
        acc_sum = 32'h00000000;
        cmd = 8'h00;
        mstep = 12'h000;
        nstep = 13'h0000;
        nrt_val = 16'h0000;
        code = 4'h0;
        d = q;
        d.nrt_irq = 1'b0;

        // Carrier tick from a fractional accumulator
        acc_sum = q.fc_acc + rgt_pkg::FC_HZ;
        if (acc_sum >= rgt_pkg::CLK_HZ)
        begin
            d.fc_acc = acc_sum - rgt_pkg::CLK_HZ;
            d.fc_tick = 1'b1;
        end
        else
        begin
            d.fc_acc = acc_sum;
            d.fc_tick = 1'b0;
        end

        // Write address and data, taken in either order
        if (s_axi_awvalid && q.awready)
        begin
            d.aw_have = 1'b1;
            d.aw_idx = s_axi_awaddr[7:2];
            d.aw_ok = (s_axi_awaddr[1:0] == 2'h0);
        end
        if (s_axi_wvalid && q.wready)
        begin
            d.w_have = 1'b1;
            d.w_data = s_axi_wdata[7:0];
            d.w_lane0 = s_axi_wstrb[0];
        end
        if (q.bvalid && s_axi_bready)
        begin
            d.bvalid = 1'b0;
        end
        wr_fire = q.aw_have && q.w_have && !q.bvalid;
        if (wr_fire)
        begin
            d.aw_have = 1'b0;
            d.w_have = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = rgt_pkg::RESP_OKAY;
            if (!q.aw_ok)
            begin
                d.bresp = rgt_pkg::RESP_SLVERR;
            end
            else if (q.w_lane0)
            begin
                case (q.aw_idx)
                    rgt_pkg::IDX_GAIN: d.gain = q.w_data;
                    rgt_pkg::IDX_MASK: d.mrt = q.w_data;
                    rgt_pkg::IDX_NRT_HI: d.nrt_hi = q.w_data;
                    rgt_pkg::IDX_NRT_LO: d.nrt_lo = q.w_data;
                    rgt_pkg::IDX_CTRL: d.ctrl = q.w_data[4:0];
                    rgt_pkg::IDX_CMD: cmd = q.w_data;
                    rgt_pkg::IDX_STATUS:
                    begin
                        if (q.w_data[rgt_pkg::ST_NRT_FLAG])
                        begin
                            d.nrt_flag = 1'b0;
                        end
                    end
                    default: d.bresp = rgt_pkg::RESP_SLVERR;
                endcase
            end
            else if (!(q.aw_idx inside {rgt_pkg::IDX_GAIN,
                rgt_pkg::IDX_MASK, rgt_pkg::IDX_NRT_HI,
                rgt_pkg::IDX_NRT_LO, rgt_pkg::IDX_CTRL,
                rgt_pkg::IDX_CMD, rgt_pkg::IDX_STATUS}))
            begin
                d.bresp = rgt_pkg::RESP_SLVERR;
            end
        end
        d.awready = !d.aw_have;
        d.wready = !d.w_have;

        // Read channel
        if (q.rvalid && s_axi_rready)
        begin
            d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && q.arready)
        begin
            ar_idx = s_axi_araddr[7:2];
            d.rvalid = 1'b1;
            d.rresp = rgt_pkg::RESP_OKAY;
            d.rdata = 32'h00000000;
            case (ar_idx)
                rgt_pkg::IDX_GAIN: d.rdata[7:0] = q.gain;
                rgt_pkg::IDX_MASK: d.rdata[7:0] = q.mrt;
                rgt_pkg::IDX_NRT_HI: d.rdata[7:0] = q.nrt_hi;
                rgt_pkg::IDX_NRT_LO: d.rdata[7:0] = q.nrt_lo;
                rgt_pkg::IDX_CTRL: d.rdata[4:0] = q.ctrl;
                rgt_pkg::IDX_CMD: d.rdata = 32'h00000000;
                rgt_pkg::IDX_STATUS:
                begin
                    d.rdata[rgt_pkg::ST_MASK] = q.mask_on;
                    d.rdata[rgt_pkg::ST_SQUELCH] = q.squelch;
                    d.rdata[rgt_pkg::ST_NRT_RUN] =
                        (q.nrt_st != rgt_pkg::NRT_IDLE);
                    d.rdata[rgt_pkg::ST_NRT_FLAG] = q.nrt_flag;
                    d.rdata[15:8] = q.gain_live;
                end
                default: d.rresp = rgt_pkg::RESP_SLVERR;
            endcase
            if (s_axi_araddr[1:0] != 2'h0)
            begin
                d.rresp = rgt_pkg::RESP_SLVERR;
                d.rdata = 32'h00000000;
            end
        end
        d.arready = !d.rvalid;

        // Direct commands
        if (cmd[rgt_pkg::CMD_SET_DEFAULT])
        begin
            d.gain = rgt_pkg::RST_GAIN;
            d.mrt = rgt_pkg::RST_MASK;
            d.nrt_hi = rgt_pkg::RST_NRT_HI;
            d.nrt_lo = rgt_pkg::RST_NRT_LO;
            d.ctrl = rgt_pkg::RST_CTRL;
        end
        if (cmd[rgt_pkg::CMD_GAIN_RELOAD])
        begin
            d.gain_live = q.gain;
        end

        // Gain split into window and stage steps
        code = q.gain_live[rgt_pkg::GAIN_AMP_LSB +: 4];
        d.amp_win = (code > rgt_pkg::GAIN_WIN_MAX) ?
            rgt_pkg::GAIN_WIN_MAX[2:0] : code[2:0];
        d.amp_stg = (code > rgt_pkg::GAIN_WIN_MAX) ?
            3'(code - rgt_pkg::GAIN_WIN_MAX) : 3'h0;
        code = q.gain_live[rgt_pkg::GAIN_PH_LSB +: 4];
        d.ph_win = (code > rgt_pkg::GAIN_WIN_MAX) ?
            rgt_pkg::GAIN_WIN_MAX[2:0] : code[2:0];
        d.ph_stg = (code > rgt_pkg::GAIN_WIN_MAX) ?
            3'(code - rgt_pkg::GAIN_WIN_MAX) : 3'h0;

        // Mask receive timer and squelch
        mstep = q.ctrl[rgt_pkg::CTRL_BR_DET] ?
            rgt_pkg::MASK_STEP_BR : rgt_pkg::MASK_STEP;
        if (tx_end)
        begin
            d.mask_on = 1'b1;
            d.mask_pre = 12'h000;
            d.mask_cnt = (q.mrt < rgt_pkg::MASK_MIN) ?
                rgt_pkg::MASK_MIN : q.mrt;
            d.sq_cnt = 12'h000;
            d.squelch = 1'b0;
        end
        else if (q.mask_on && q.fc_tick)
        begin
            if (q.sq_cnt != rgt_pkg::SQ_DELAY_FC)
            begin
                d.sq_cnt = q.sq_cnt + 12'h001;
            end
            if (q.sq_cnt == rgt_pkg::SQ_DELAY_FC - 12'h001)
            begin
                d.squelch = q.ctrl[rgt_pkg::CTRL_SQ_AUTO];
            end
            if (q.mask_pre == mstep - 12'h001)
            begin
                d.mask_pre = 12'h000;
                d.mask_cnt = q.mask_cnt - 8'h01;
                if (q.mask_cnt == 8'h01)
                begin
                    d.mask_on = 1'b0;
                    d.squelch = 1'b0;
                end
            end
            else
            begin
                d.mask_pre = q.mask_pre + 12'h001;
            end
        end
        d.rx_out = rx_raw && !d.mask_on;

        // No-response timer
        nrt_val = {q.nrt_hi, q.nrt_lo};
        nstep = q.ctrl[rgt_pkg::CTRL_NRT_STEP] ?
            rgt_pkg::NRT_STEP_LONG : {1'b0, rgt_pkg::NRT_STEP};
        case (q.nrt_st)
            rgt_pkg::NRT_IDLE:
            begin
            end
            rgt_pkg::NRT_WAIT:
            begin
                if (ext_field_det)
                begin
                    d.nrt_st = rgt_pkg::NRT_RUN;
                end
            end
            rgt_pkg::NRT_RUN:
            begin
                if (rx_detect)
                begin
                    d.nrt_st = rgt_pkg::NRT_IDLE;
                end
                else if (q.fc_tick)
                begin
                    if (q.nrt_pre == nstep - 13'h0001)
                    begin
                        d.nrt_pre = 13'h0000;
                        d.nrt_cnt = q.nrt_cnt + 16'h0001;
                        if (q.nrt_cnt + 16'h0001 >= nrt_val)
                        begin
                            d.nrt_st = rgt_pkg::NRT_IDLE;
                            d.nrt_irq = 1'b1;
                            d.nrt_flag = 1'b1;
                        end
                    end
                    else
                    begin
                        d.nrt_pre = q.nrt_pre + 13'h0001;
                    end
                end
            end
            default: d.nrt_st = rgt_pkg::NRT_IDLE;
        endcase
        if ((tx_end || cmd[rgt_pkg::CMD_START_NRT]) &&
            nrt_val != 16'h0000)
        begin
            d.nrt_pre = 13'h0000;
            d.nrt_cnt = 16'h0000;
            if (tx_end && q.ctrl[rgt_pkg::CTRL_NFC_MODE] &&
                !q.ctrl[rgt_pkg::CTRL_ACTIVE] &&
                !cmd[rgt_pkg::CMD_START_NRT])
            begin
                d.nrt_st = rgt_pkg::NRT_WAIT;
            end
            else
            begin
                d.nrt_st = rgt_pkg::NRT_RUN;
            end
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            q <= '0;
            q.gain <= rgt_pkg::RST_GAIN;
            q.mrt <= rgt_pkg::RST_MASK;
            q.nrt_hi <= rgt_pkg::RST_NRT_HI;
            q.nrt_lo <= rgt_pkg::RST_NRT_LO;
            q.ctrl <= rgt_pkg::RST_CTRL;
            q.nrt_st <= rgt_pkg::NRT_IDLE;
        end
        else
        begin
            q <= d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign s_axi_awready = q.awready;
    assign s_axi_wready = q.wready;
    assign s_axi_bresp = q.bresp;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_arready = q.arready;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
    assign s_axi_rvalid = q.rvalid;
    assign rx_gated = q.rx_out;
    assign mask_active = q.mask_on;
    assign squelch_on = q.squelch;
    assign no_reply_irq = q.nrt_irq;
    assign amp_window_steps = q.amp_win;
    assign amp_stage_steps = q.amp_stg;
    assign phase_window_steps = q.ph_win;
    assign phase_stage_steps = q.ph_stg;

endmodule : rgt_top

/* verif/rgt_props.sv */
// Checker on the ports of the gain and response timer block.
// Assumes it is bound into rgt_top; one clock, synchronous reset.
`timescale 1ns/1ps
module rgt_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic tx_end,
    input wire logic rx_raw,
    input wire logic rx_gated,
    input wire logic mask_active,
    input wire logic squelch_on,
    input wire logic no_reply_irq,
    input wire logic [2:0] amp_window_steps,
    input wire logic [2:0] amp_stage_steps,
    input wire logic [2:0] phase_window_steps
);
    // ********
    // Cycles since end of transmit
    // ********
    localparam int MIN_CYC = 1870;
    logic [15:0] cyc_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn || tx_end)
            cyc_q <= 16'h0000;
        else if (cyc_q != 16'hffff)
            cyc_q <= cyc_q + 16'h0001;
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_mask_hold;
        mask_active [*8];
    endsequence
    sequence s_quiet;
        !mask_active && !$past(mask_active) && !$past(tx_end)
            && !$past(tx_end, 2) && $past(aresetn);
    endsequence

    a_mask_start: assert property (tx_end |-> ##2 s_mask_hold)
        else $error("mask not raised after end of transmit");
    a_gate_mask: assert property (
        mask_active && $past(mask_active) |-> $past(rx_gated) == 1'b0)
        else $error("receiver output passed while masked");
    a_gate_pass: assert property (
        s_quiet |-> rx_gated == $past(rx_raw))
        else $error("receiver output not passed when unmasked");
    a_mask_min: assert property (
        $fell(mask_active) |-> cyc_q >= MIN_CYC)
        else $error("mask shorter than four steps");
    a_sq_delay: assert property (
        $rose(squelch_on) |-> cyc_q >= MIN_CYC)
        else $error("squelch started too early");
    a_sq_in_mask: assert property (
        squelch_on |-> mask_active || $past(mask_active))
        else $error("squelch outlived the mask");
    a_irq_pulse: assert property (no_reply_irq |=> !no_reply_irq)
        else $error("no reply interrupt longer than one cycle");
    a_win_max: assert property (
        amp_window_steps <= 3'h4 && phase_window_steps <= 3'h4)
        else $error("digitizer window beyond four steps");
    a_stage_order: assert property (
        amp_stage_steps != 3'h0 |-> amp_window_steps == 3'h4)
        else $error("stage cut without full window");
endmodule : rgt_props

bind rgt_top rgt_props u_props (
    .aclk, .aresetn, .tx_end, .rx_raw, .rx_gated, .mask_active,
    .squelch_on, .no_reply_irq, .amp_window_steps, .amp_stage_steps,
    .phase_window_steps
);

/* verif/rgt_rf_model.sv */
// Model of the RF front end beside the receiver block.
// Assumes one clock; events change just after a rising edge.
`timescale 1ns/1ps
module rgt_rf_model (
    input wire logic aclk,
    output logic tx_end,
    output logic ext_field_det,
    output logic rx_detect,
    output logic rx_raw
);
    // ********
    // Receiver output and events
    // ********
    logic [7:0] pat_q;

    initial
    begin
        tx_end = 1'b0;
        ext_field_det = 1'b0;
        rx_detect = 1'b0;
        pat_q = 8'h5a;
    end

    // Receiver output never rests, so gating faults show
    always @(posedge aclk)
        pat_q <= {pat_q[6:0], pat_q[7] ^ pat_q[5] ^ pat_q[4] ^ pat_q[3]};
    assign rx_raw = pat_q[0];

    // One-cycle end of transmit (0) or reply seen (1)
    task automatic pulse(input int which);
        @(posedge aclk);
        if (which == 0) tx_end <= 1'b1;
        else rx_detect <= 1'b1;
        @(posedge aclk);
        tx_end <= 1'b0;
        rx_detect <= 1'b0;
    endtask : pulse

    task automatic field(input logic on);
        @(posedge aclk);
        ext_field_det <= on;
    endtask : field
endmodule : rgt_rf_model

/* verif/rx_gain_and_response_timers_tb_top.sv */
// Self-checking bench for the gain and response timer block.
// Assumes rgt_pkg, rgt_top, rgt_props and rgt_rf_model compiled first.
`timescale 1ns/1ps
module rx_gain_and_response_timers_tb_top;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, tx_end, ext_field_det, rx_detect;
    logic rx_raw, rx_gated, mask_active, squelch_on, no_reply_irq;
    logic [2:0] amp_window_steps, amp_stage_steps;
    logic [2:0] phase_window_steps, phase_stage_steps;
    logic [11:0] gain_live, g_exp;
    logic [33:0] wq[$], rq[$];
    logic [31:0] seed = 32'h2c6a;
    int bad_count = 0;
    int check_count = 0;
    localparam logic [33:0] BAD = {rgt_pkg::RESP_SLVERR, 32'h0};

    always #5 aclk = ~aclk;
    assign gain_live = {amp_window_steps, amp_stage_steps,
        phase_window_steps, phase_stage_steps};

    rgt_top u_dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .tx_end, .ext_field_det, .rx_detect,
        .rx_raw, .rx_gated, .mask_active, .squelch_on, .no_reply_irq,
        .amp_window_steps, .amp_stage_steps, .phase_window_steps,
        .phase_stage_steps
    );
    rgt_rf_model u_rf (.aclk, .tx_end, .ext_field_det, .rx_detect, .rx_raw);

    // ********
    // Tasks
    // ********
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    function automatic logic [5:0] split(input logic [3:0] c);
        return (c > 4'h4) ? {3'h4, 3'(c - 4'h4)} : {3'(c), 3'h0};
    endfunction : split

    task automatic check(input string nm, input logic [33:0] seen,
        input logic [33:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // Counts in carrier periods; allow for carrier tick jitter
    task automatic near(input string nm, input int seen, input int fc);
        int e;
        e = fc * 10000 / 1356;
        check(nm, 34'((seen >= e - 10 && seen <= e + 10) ? e : seen), 34'(e));
    endtask : near

    task automatic wr(input logic [7:0] a, input logic [7:0] d,
        input logic [1:0] r = rgt_pkg::RESP_OKAY,
        input logic [3:0] st = 4'hf);
        wq.push_back({32'h0, r});
        seed = lfsr(seed);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {seed[31:8], d};
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        rq.push_back(e);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
    endtask : rd

    // Mask length, and squelch start (0 means none expected)
    task automatic tx_meas(input int mfc, input int sfc);
        int n;
        int s;
        n = 0;
        s = 0;
        u_rf.pulse(0);
        do
        begin
            @(posedge aclk);
            #1;
            n++;
            if (squelch_on === 1'b1 && s == 0) s = n;
        end
        while (mask_active === 1'b1 && n < 40000);
        near("mask time", n, mfc);
        if (sfc > 0) near("squelch start", s, sfc);
        else check("squelch off", 34'(s), 34'h0);
    endtask : tx_meas

    // Interrupt time in carrier periods, or none within lim (fc 0)
    task automatic irq_case(input int lim, input int fc);
        int n;
        n = 0;
        while (no_reply_irq !== 1'b1 && n < lim)
        begin
            @(posedge aclk);
            #1;
            n++;
        end
        if (fc > 0) near("irq time", n, fc);
        else check("no irq", 34'(n), 34'(lim));
    endtask : irq_case

    task automatic final_report();
        $display("Checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : final_report

    always @(posedge aclk)
    begin
        if ((s_axi_bvalid & s_axi_bready) === 1'b1)
            check("wr", {32'h0, s_axi_bresp}, wq.pop_front());
        if ((s_axi_rvalid & s_axi_rready) === 1'b1)
            check("rd", {s_axi_rresp, s_axi_rdata}, rq.pop_front());
    end

    initial
    begin
        #1000000;
        bad_count++;
        final_report();
    end

    // ********
    // Sequence
    // ********
    initial
    begin
        logic [3:0] ph;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf;
        g_exp = 12'h000;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(8'h34, 34'h0);
        rd(8'h38, 34'h8);
        rd(8'h3c, 34'h0);
        rd(8'h40, 34'h0);
        rd(8'h80, 34'h10);
        rd(8'h44, BAD);
        rd(8'h3a, BAD);
        wr(8'h44, 8'h5a, rgt_pkg::RESP_SLVERR);
        wr(8'h3c, 8'ha5);
        rd(8'h3c, 34'ha5);
        wr(8'h3c, 8'h00);
        for (int c = 0; c <= 10; c++)
        begin
            seed = lfsr(seed);
            ph = 4'(seed % 32'hb);
            wr(8'h34, {4'(c), ph});
            check("gain held", 34'(gain_live), 34'(g_exp));
            wr(8'h84, 8'h02);
            repeat (3) @(posedge aclk);
            g_exp = {split(4'(c)), split(ph)};
            check("gain", 34'(gain_live), 34'(g_exp));
        end
        wr(8'h34, 8'h77, rgt_pkg::RESP_OKAY, 4'he);
        rd(8'h34, {26'h0, 4'ha, ph});
        wr(8'h38, 8'h02);
        tx_meas(256, 0);
        wr(8'h38, 8'h0b);
        tx_meas(704, 256);
        wr(8'h80, 8'h18);
        wr(8'h38, 8'h03);
        tx_meas(2048, 256);
        wr(8'h80, 8'h00);
        tx_meas(256, 0);
        wr(8'h40, 8'h01);
        u_rf.pulse(0);
        irq_case(700, 64);
        rd(8'h88, {18'h0, 4'ha, ph, 8'h09});
        wr(8'h88, 8'h08);
        rd(8'h88, {18'h0, 4'ha, ph, 8'h01});
        u_rf.pulse(0);
        repeat (100) @(posedge aclk);
        u_rf.pulse(1);
        irq_case(800, 0);
        wr(8'h40, 8'h00);
        u_rf.pulse(0);
        irq_case(800, 0);
        wr(8'h40, 8'h01);
        wr(8'h80, 8'h02);
        u_rf.pulse(0);
        irq_case(800, 0);
        u_rf.field(1'b1);
        irq_case(700, 64);
        u_rf.field(1'b0);
        wr(8'h80, 8'h06);
        u_rf.pulse(0);
        irq_case(700, 64);
        wr(8'h80, 8'h00);
        wr(8'h84, 8'h04);
        repeat (200) @(posedge aclk);
        wr(8'h84, 8'h04);
        irq_case(700, 64);
        wr(8'h80, 8'h01);
        u_rf.pulse(0);
        irq_case(31000, 4096);
        wr(8'h38, 8'h33);
        wr(8'h3c, 8'h12);
        wr(8'h84, 8'h01);
        rd(8'h38, 34'h8);
        rd(8'h3c, 34'h0);
        rd(8'h80, 34'h10);
        final_report();
    end
endmodule : rx_gain_and_response_timers_tb_top
